//--- src/lcg_defines.svh
`ifndef LCG_DEFINES_SVH
`define LCG_DEFINES_SVH

// register offsets on the plain register port
`define LCG_ADDR_W          8
`define LCG_TERM_ADDR       8'h00
`define LCG_MIRROR_ADDR     8'h01

// gate d term select field positions (true / inverted per data input)
`define LCG_IN4_TRUE_BIT    7
`define LCG_IN4_INV_BIT     6
`define LCG_IN3_TRUE_BIT    5
`define LCG_IN3_INV_BIT     4
`define LCG_IN2_TRUE_BIT    3
`define LCG_IN2_INV_BIT     2
`define LCG_IN1_TRUE_BIT    1
`define LCG_IN1_INV_BIT     0

// output mirror field positions and reset values
`define LCG_MIRROR_SECOND_BIT 1
`define LCG_MIRROR_FIRST_BIT  0
`define LCG_MIRROR_RESET    2'h0
`define LCG_MIRROR_PAD      6'h00
`define LCG_RD_RESET        8'h00
`define LCG_IN_RESET        4'h0

`endif

//--- src/lcg_gate_d.sv
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "lcg_defines.svh"

module lcg_gate_d
	import lcg_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wr_data,
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	output logic      [7:0] reg_rd_data,
	input  wire logic [3:0] cell_data_in,
	input  wire logic       first_cell_output,
	input  wire logic       second_cell_output,
	output logic            gate_d_out
);

	lcg_state_type state_reg;
	lcg_state_type state_next;
	lcg_keep_type  keep_reg;
	lcg_keep_type  keep_next;
	lcg_bus_type   bus;

	// one true/inverted pair of enables applied to one data input
	function automatic logic term_pair(input logic din, input logic true_en, input logic inv_en);
		term_pair = (din & true_en) | (~din & inv_en);
	endfunction : term_pair

	// address decodes for the checks below; term_wr_hit is also used by the datapath
	function automatic logic term_wr_hit(input lcg_bus_type b);
		term_wr_hit = b.wr_en && b.addr == `LCG_TERM_ADDR;
	endfunction : term_wr_hit

	function automatic logic term_rd_hit(input lcg_bus_type b);
		term_rd_hit = b.rd_en && b.addr == `LCG_TERM_ADDR;
	endfunction : term_rd_hit

	function automatic logic mirror_rd_hit(input lcg_bus_type b);
		mirror_rd_hit = b.rd_en && b.addr == `LCG_MIRROR_ADDR;
	endfunction : mirror_rd_hit

	assign bus = '{addr: reg_addr, wr_data: reg_wr_data, wr_en: reg_wr_en, rd_en: reg_rd_en};

	always_comb
	begin
		state_next = state_reg;
		keep_next = keep_reg;
		// pins are asynchronous; only in_sync is read by the gate
		state_next.in_meta = cell_data_in;
		state_next.in_sync = state_reg.in_meta;
		state_next.mirror = {second_cell_output, first_cell_output};
		state_next.gate_out =
			term_pair(state_reg.in_sync[3], keep_reg.terms[`LCG_IN4_TRUE_BIT],
				keep_reg.terms[`LCG_IN4_INV_BIT]) |
			term_pair(state_reg.in_sync[2], keep_reg.terms[`LCG_IN3_TRUE_BIT],
				keep_reg.terms[`LCG_IN3_INV_BIT]) |
			term_pair(state_reg.in_sync[1], keep_reg.terms[`LCG_IN2_TRUE_BIT],
				keep_reg.terms[`LCG_IN2_INV_BIT]) |
			term_pair(state_reg.in_sync[0], keep_reg.terms[`LCG_IN1_TRUE_BIT],
				keep_reg.terms[`LCG_IN1_INV_BIT]);
		if (term_wr_hit(bus))
		begin
			keep_next.terms = bus.wr_data;
		end
		// writes to the mirror are dropped: it has no writable bits
		state_next.rd_data = `LCG_RD_RESET;
		if (bus.rd_en)
		begin
			case (bus.addr)
				`LCG_TERM_ADDR:
				begin
					state_next.rd_data = keep_reg.terms;
				end
				`LCG_MIRROR_ADDR:
				begin
					state_next.rd_data = {`LCG_MIRROR_PAD, state_reg.mirror};
				end
				default:
				begin
					state_next.rd_data = `LCG_RD_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_reg.in_meta <= `LCG_IN_RESET;
			state_reg.in_sync <= `LCG_IN_RESET;
			state_reg.mirror <= `LCG_MIRROR_RESET;
			state_reg.gate_out <= 1'b0;
			state_reg.rd_data <= `LCG_RD_RESET;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// no reset on purpose: selects hold their value across rst_b
	always_ff @(posedge ref_clk)
	begin
		keep_reg <= keep_next;
	end

	assign reg_rd_data = state_reg.rd_data;
	assign gate_d_out = state_reg.gate_out;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// register port
	term_write_a: assert property
	(
		term_wr_hit(bus) |=> keep_reg.terms == $past(bus.wr_data)
	)
		else $error("term select did not take the written value");

	term_hold_a: assert property
	(
		!term_wr_hit(bus) |=> $stable(keep_reg.terms)
	)
		else $error("term select changed without a write");

	term_read_a: assert property
	(
		term_rd_hit(bus) |=> reg_rd_data == $past(keep_reg.terms)
	)
		else $error("term select read back wrong");

	mirror_track_a: assert property
	(
		1'b1 |=> state_reg.mirror == $past({second_cell_output, first_cell_output})
	)
		else $error("mirror does not follow the cell outputs");

	mirror_read_a: assert property
	(
		mirror_rd_hit(bus) && $past(rst_b)
		|=> reg_rd_data[1:0] == $past({second_cell_output, first_cell_output}, 2)
	)
		else $error("mirror read shows wrong cell outputs");

	mirror_nowrite_a: assert property
	(
		bus.wr_en && bus.addr == `LCG_MIRROR_ADDR |=> $stable(keep_reg.terms)
	)
		else $error("mirror write disturbed the term select");

	mirror_pad_a: assert property
	(
		mirror_rd_hit(bus) |=> reg_rd_data[7:2] == `LCG_MIRROR_PAD
	)
		else $error("unimplemented mirror bits not zero");

	rd_idle_a: assert property
	(
		!bus.rd_en |=> reg_rd_data == `LCG_RD_RESET
	)
		else $error("read data not zero outside a read");

	unmapped_read_a: assert property
	(
		bus.rd_en && !term_rd_hit(bus) && !mirror_rd_hit(bus) |=> reg_rd_data == `LCG_RD_RESET
	)
		else $error("unmapped address did not read zero");

	// reset values; these run while rst_b is low
	rst_mirror_a: assert property
	(
		disable iff (1'b0) !rst_b ##1 !rst_b |-> state_reg.mirror == `LCG_MIRROR_RESET
	)
		else $error("mirror not cleared by reset");

	rst_read_a: assert property
	(
		disable iff (1'b0) !rst_b ##1 !rst_b |-> reg_rd_data == `LCG_RD_RESET
	)
		else $error("read data not cleared by reset");

	rst_gate_a: assert property
	(
		disable iff (1'b0) !rst_b ##1 !rst_b |-> !gate_d_out
	)
		else $error("gate output not cleared by reset");

	rst_sync_a: assert property
	(
		disable iff (1'b0) !rst_b ##1 !rst_b |-> state_reg.in_sync == `LCG_IN_RESET
	)
		else $error("input synchroniser not cleared by reset");

	// single terms
	in4_true_a: assert property
	(
		keep_reg.terms == 8'h80 |=> gate_d_out == $past(state_reg.in_sync[3])
	)
		else $error("fourth input true term wrong");

	in4_inv_a: assert property
	(
		keep_reg.terms == 8'h40 |=> gate_d_out == !$past(state_reg.in_sync[3])
	)
		else $error("fourth input inverted term wrong");

	lat_in4_a: assert property
	(
		(keep_reg.terms == 8'h80) [*3] |=> gate_d_out == $past(cell_data_in[3], 3)
	)
		else $error("fourth input late or early at the gate");

	in3_true_a: assert property
	(
		keep_reg.terms == 8'h20 |=> gate_d_out == $past(state_reg.in_sync[2])
	)
		else $error("third input true term wrong");

	in3_inv_a: assert property
	(
		keep_reg.terms == 8'h10 |=> gate_d_out == !$past(state_reg.in_sync[2])
	)
		else $error("third input inverted term wrong");

	lat_in3_a: assert property
	(
		(keep_reg.terms == 8'h10) [*3] |=> gate_d_out == !$past(cell_data_in[2], 3)
	)
		else $error("third input late or early at the gate");

	in2_true_a: assert property
	(
		keep_reg.terms == 8'h08 |=> gate_d_out == $past(state_reg.in_sync[1])
	)
		else $error("second input true term wrong");

	in2_inv_a: assert property
	(
		keep_reg.terms == 8'h04 |=> gate_d_out == !$past(state_reg.in_sync[1])
	)
		else $error("second input inverted term wrong");

	in1_true_a: assert property
	(
		keep_reg.terms == 8'h02 |=> gate_d_out == $past(state_reg.in_sync[0])
	)
		else $error("first input true term wrong");

	in1_inv_a: assert property
	(
		keep_reg.terms == 8'h01 |=> gate_d_out == !$past(state_reg.in_sync[0])
	)
		else $error("first input inverted term wrong");

	lat_in1_a: assert property
	(
		(keep_reg.terms == 8'h01) [*3] |=> gate_d_out == !$past(cell_data_in[0], 3)
	)
		else $error("first input late or early at the gate");

	// term combinations
	gate_or_a: assert property
	(
		keep_reg.terms == 8'h00 |=> !gate_d_out
	)
		else $error("gate high with no terms selected");

	gate_pair_a: assert property
	(
		keep_reg.terms == 8'hc0 |=> gate_d_out
	)
		else $error("true or inverted of one input must give one");

	pair3_a: assert property
	(
		keep_reg.terms == 8'h30 |=> gate_d_out
	)
		else $error("both third input terms must give one");

	pair2_a: assert property
	(
		keep_reg.terms == 8'h0c |=> gate_d_out
	)
		else $error("both second input terms must give one");

	pair1_a: assert property
	(
		keep_reg.terms == 8'h03 |=> gate_d_out
	)
		else $error("both first input terms must give one");

	all_true_a: assert property
	(
		keep_reg.terms == 8'haa |=> gate_d_out == $past(|state_reg.in_sync)
	)
		else $error("gate is not the or of all true inputs");

	all_inv_a: assert property
	(
		keep_reg.terms == 8'h55 |=> gate_d_out == $past(!(&state_reg.in_sync))
	)
		else $error("gate is not the or of all inverted inputs");

	all_terms_a: assert property
	(
		keep_reg.terms == 8'hff |=> gate_d_out
	)
		else $error("gate low with every term selected");

endmodule : lcg_gate_d

`default_nettype wire

//--- src/lcg_pkg.sv
package lcg_pkg;

	// everything that is cleared by rst_b
	typedef struct packed
	{
		logic [3:0] in_meta;
		logic [3:0] in_sync;
		logic [1:0] mirror;
		logic       gate_out;
		logic [7:0] rd_data;
	} lcg_state_type;

	// term selects have no reset at all and keep their value across rst_b
	typedef struct packed
	{
		logic [7:0] terms;
	} lcg_keep_type;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wr_data;
		logic       wr_en;
		logic       rd_en;
	} lcg_bus_type;

endpackage : lcg_pkg

//--- test/lcg_far_model.sv
`timescale 1ns/10ps
`default_nettype none
// stands in for the pins and the two cells; levels change only after an edge
module lcg_far_model
(
	input  wire logic       ref_clk,
	input  wire logic [5:0] next_val,
	output logic      [3:0] cell_data_in,
	output logic            first_cell_output,
	output logic            second_cell_output
);
	always_ff @(posedge ref_clk)
		{second_cell_output, first_cell_output, cell_data_in} <= next_val;
endmodule : lcg_far_model
`default_nettype wire

//--- test/lcg_gate_d_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lcg_gate_d_tb;
	import lcg_pkg::*;
	logic       ref_clk = 0, rst_b = 0, wr = 0, rd = 0, rd_q = 0, c1, c2, gout;
	logic [7:0] addr = 0, wd = 0, rdata, t;
	// one select at a time, then pairs and whole rows, before the random ones
	logic [7:0] dir_t [16] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
		8'h00, 8'hc0, 8'h30, 8'h0c, 8'h03, 8'haa, 8'h55, 8'hff};
	logic [5:0] nv = 0, r;
	logic [3:0] din;
	logic [7:0] exp_q[$];
	int         n_mismatch = 0, num_checks = 0;
	always #10 ref_clk = ~ref_clk;
	lcg_far_model lcg_far_model_i (.ref_clk(ref_clk), .next_val(nv), .cell_data_in(din),
		.first_cell_output(c1), .second_cell_output(c2));
	lcg_gate_d lcg_gate_d_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(addr), .reg_wr_data(wd),
		.reg_wr_en(wr), .reg_rd_en(rd), .reg_rd_data(rdata), .cell_data_in(din),
		.first_cell_output(c1), .second_cell_output(c2), .gate_d_out(gout));
	function automatic logic gexp(input logic [7:0] s, input logic [3:0] d);
		gexp = 0;
		for (int k = 0; k < 4; k++)
			gexp |= (d[k] & s[2*k+1]) | (~d[k] & s[2*k]);
	endfunction : gexp
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : chk
	task automatic gchk(input logic e);
		repeat (4) @(posedge ref_clk);
		// look mid-cycle, away from the edge that moves gate_d_out
		@(negedge ref_clk);
		chk({7'h0, gout}, {7'h0, e}, "gate out");
	endtask : gchk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		{wr, addr, wd} <= {1'b1, a, d};
		@(posedge ref_clk);
		wr <= 0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		{rd, addr} <= {1'b1, a};
		exp_q.push_back(e);
		@(posedge ref_clk);
		rd <= 0;
	endtask : rd_reg
	// read data stand only in the cycle after the strobe
	always @(posedge ref_clk)
	begin
		rd_q <= rd;
		if (rd_q)
			chk(rdata, exp_q.pop_front(), "read data");
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	initial
	begin
		#200000;
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		void'($urandom(32'hc32c184b));
		repeat (6) @(posedge ref_clk);
		rst_b <= 1;
		for (int i = 0; i < 48; i++)
		begin
			t = $urandom;
			if (i < 16)
				t = dir_t[i];
			r = $urandom;
			nv <= r;
			wr_reg(8'h00, t);
			gchk(gexp(t, r[3:0]));
			rd_reg(8'h00, t);
			rd_reg(8'h01, {6'h00, r[5:4]});
			wr_reg(8'h01, 8'hff);
			rd_reg(8'h01, {6'h00, r[5:4]});
			rd_reg(8'h5a, 8'h00);
			$display("test %0d done", i);
		end
		// a mid-run reset must leave the term selects alone
		@(posedge ref_clk);
		rst_b <= 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		rd_reg(8'h00, t);
		gchk(gexp(t, r[3:0]));
		repeat (3) @(posedge ref_clk);
		$display("test reset done");
		finish_test();
	end
endmodule : lcg_gate_d_tb
`default_nettype wire
